// [verilog/drive_control_param_bank.sv]
`timescale 1ns/1ns
`include "drive_params.svh"
module drive_control_param_bank #(
  parameter int unsigned PERSIST_WAIT = `PERSIST_WAIT_CYC
) (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic                       warm_restart,
  // Parameter access port
  input  wire logic [15:0]                param_addr,
  input  wire logic                       param_wr,
  input  wire logic                       param_rd,
  input  wire logic [31:0]                param_wdata,
  output logic      [31:0]                param_rdata,
  output logic                            param_ack,
  output logic                            param_err,
  // Drive state inputs
  input  wire logic                       multi_turn_sensor,
  input  wire logic [5:0]                 drive_state_bits,
  input  wire logic                       voltage_enabled,
  input  wire logic                       warning,
  input  wire logic                       remote,
  input  wire logic                       target_reached,
  input  wire logic                       mode_status,
  input  wire logic                       position_error,
  input  wire logic                       reference_valid,
  // Decoded control outputs
  output logic                            switch_on,
  output logic                            enable_voltage,
  output logic                            quick_stop,
  output logic                            enable_operation,
  output logic      [2:0]                 mode_ctrl,
  output logic                            fault_reset,
  output logic                            halt,
  output drive_pkg::op_mode_e             op_mode,
  output drive_pkg::cmd_source_e          cmd_source,
  output logic      [31:0]                enc_preset_active,
  output logic      [13:0]                index_offset,
  output logic                            persist_busy
);
  import drive_pkg::*;

  logic [15:0]  ctrl_r;
  logic [15:0]  status_r;
  cmd_source_e  cmd_src_sto_r;
  logic [31:0]  preset_pend_r;
  logic [31:0]  preset_commit_r;
  logic         persist_done;
  logic         wr_ctrl;
  logic         wr_mode;
  logic         wr_src;
  logic         wr_preset;
  logic         wr_status;
  logic         mapped;
  logic         accept;

  // Accepted operating mode codes
  function automatic logic mode_ok(input logic [15:0] code);
    case (code)
      OPM_PROFILE_POS, OPM_PROFILE_VEL, OPM_HOMING, OPM_JOG, OPM_GEAR,
      OPM_CURRENT, OPM_SPEED, OPM_OSCILLATOR: mode_ok = 1'b1;
      default:                                mode_ok = 1'b0;
    endcase
  endfunction

  // Highest preset value for the fitted sensor
  function automatic logic [31:0] preset_max(input logic multi);
    preset_max = multi ? (`MULTI_TURNS * `POS_PER_REV) - 32'h00000001
                       : `POS_PER_REV - 32'h00000001;
  endfunction

  // Address decode; writes during a restart are refused, reads are still answered
  assign accept    = param_wr && !warm_restart;
  assign wr_ctrl   = accept && param_addr == `ADDR_CTRL_WORD;
  assign wr_mode   = accept && param_addr == `ADDR_OPMODE && mode_ok(param_wdata[15:0]);
  assign wr_src    = accept && param_addr == `ADDR_CMD_SOURCE && param_wdata[15:2] == 14'h0000;
  assign wr_preset = accept && param_addr == `ADDR_ENC_PRESET
                     && param_wdata <= preset_max(multi_turn_sensor);
  assign wr_status = param_wr && param_addr == `ADDR_STATUS_WORD;
  assign mapped    = param_addr == `ADDR_CTRL_WORD || param_addr == `ADDR_OPMODE
                     || param_addr == `ADDR_CMD_SOURCE || param_addr == `ADDR_ENC_PRESET
                     || param_addr == `ADDR_STATUS_WORD;

  // Control word; reserved bits are forced to zero whatever the master sends
  always_ff @(posedge mclk) begin
    if (sys_rst || warm_restart) begin
      ctrl_r <= `CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= param_wdata[15:0] & `CW_USED_MASK;
    end
  end

  assign switch_on        = ctrl_r[`CW_SWITCH_ON];
  assign enable_voltage   = ctrl_r[`CW_ENABLE_VOLTAGE];
  assign quick_stop       = ctrl_r[`CW_QUICK_STOP];
  assign enable_operation = ctrl_r[`CW_ENABLE_OP];
  assign mode_ctrl        = ctrl_r[`CW_MODE_HI:`CW_MODE_LO];
  assign fault_reset      = ctrl_r[`CW_FAULT_RESET];
  assign halt             = ctrl_r[`CW_HALT];

  // Operating mode; unknown codes leave the previous mode in force
  always_ff @(posedge mclk) begin
    if (sys_rst || warm_restart) begin
      op_mode <= op_mode_e'(`OPMODE_RST);
    end else if (wr_mode) begin
      op_mode <= op_mode_e'(param_wdata[15:0]);
    end
  end

  // Status word sampled each cycle; writes never reach it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_r <= 16'h0000;
    end else begin
      status_r <= {reference_valid, 1'b0, position_error, mode_status, 1'b0,
                   target_reached, remote, ctrl_r[`CW_HALT], warning,
                   drive_state_bits[5:4], voltage_enabled, drive_state_bits[3:0]};
    end
  end

  // Command source: stored copy is persistent, active copy is loaded at power-on
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmd_src_sto_r <= cmd_source_e'(`CMD_SRC_RST);
      cmd_source    <= cmd_source_e'(`CMD_SRC_RST);
    end else if (warm_restart) begin
      cmd_source    <= cmd_src_sto_r;
    end else if (wr_src) begin
      cmd_src_sto_r <= cmd_source_e'(param_wdata[1:0]);
      if (cmd_source == SRC_UNDEFINED) begin
        cmd_source  <= cmd_source_e'(param_wdata[1:0]);
      end
    end
  end

  // Preset only counts as stored once the persist wait has run out
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      preset_pend_r     <= `PRESET_RST;
      preset_commit_r   <= `PRESET_RST;
      enc_preset_active <= `PRESET_RST;
    end else if (warm_restart) begin
      preset_pend_r     <= preset_commit_r;
      enc_preset_active <= preset_commit_r;
    end else begin
      if (wr_preset) begin
        preset_pend_r   <= param_wdata;
      end
      if (persist_done) begin
        preset_commit_r <= preset_pend_r;
      end
    end
  end

  // Index pulse position follows the active preset within one revolution
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      index_offset <= 14'h0000;
    end else begin
      index_offset <= enc_preset_active[13:0];
    end
  end

  persist_timer #(
    .WAIT_CYC (PERSIST_WAIT)
  ) u_persist (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .start   (wr_preset),
    .abort   (warm_restart),
    .busy    (persist_busy),
    .done    (persist_done)
  );

  // Answer one cycle after every access; refused or unmapped ones flag an error
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      param_ack   <= 1'b0;
      param_err   <= 1'b0;
      param_rdata <= 32'h00000000;
    end else begin
      param_ack   <= param_wr || param_rd;
      param_err   <= (param_wr && !(wr_ctrl || wr_mode || wr_src || wr_preset))
                     || (param_rd && !mapped);
      param_rdata <= 32'h00000000;
      if (param_rd) begin
        case (param_addr)
          `ADDR_CTRL_WORD:   param_rdata <= {16'h0000, ctrl_r};
          `ADDR_OPMODE:      param_rdata <= {16'h0000, 16'(op_mode)};
          `ADDR_STATUS_WORD: param_rdata <= {16'h0000, status_r};
          `ADDR_CMD_SOURCE:  param_rdata <= {30'h00000000, 2'(cmd_src_sto_r)};
          `ADDR_ENC_PRESET:  param_rdata <= preset_pend_r;
          default:           param_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  AST_CTRL_RSVD_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_r[15:9] == 7'h00) else $error("reserved control bits set");
  AST_OPMODE_REJECT: assert property (@(posedge mclk) disable iff (sys_rst)
    param_wr && !warm_restart && param_addr == `ADDR_OPMODE && !mode_ok(param_wdata[15:0])
    |=> $stable(op_mode) && param_err) else $error("invalid mode code accepted");
  AST_STATUS_MAP: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 status_r[`SW_VOLTAGE] == $past(voltage_enabled) && status_r[`SW_TARGET] == $past(target_reached)
    && status_r[`SW_HALT] == $past(ctrl_r[`CW_HALT])) else $error("status flags misplaced");
  AST_STATUS_FLAGS: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 status_r[`SW_POS_ERR] == $past(position_error) && status_r[`SW_REF_OK] == $past(reference_valid)
    && !status_r[11]) else $error("status error flags misplaced");
  AST_SRC_DEFERRED: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_src && cmd_source != SRC_UNDEFINED |=> $stable(cmd_source)) else $error("source changed early");
  AST_SRC_FIRST_SETUP: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_src && cmd_source == SRC_UNDEFINED |=> cmd_source == $past(param_wdata[1:0]))
    else $error("first setup source not applied");
  AST_PRESET_RANGE: assert property (@(posedge mclk) disable iff (sys_rst)
    param_wr && !warm_restart && param_addr == `ADDR_ENC_PRESET && !multi_turn_sensor
    && param_wdata[31:14] != 18'h00000 |=> $stable(preset_pend_r) && param_err)
    else $error("preset above one revolution accepted");
  AST_PRESET_DEFERRED: assert property (@(posedge mclk) disable iff (sys_rst)
    !warm_restart |=> $stable(enc_preset_active)) else $error("preset active without restart");
  AST_INDEX_MOVES: assert property (@(posedge mclk) disable iff (sys_rst)
    warm_restart |-> ##2 index_offset == $past(preset_commit_r[13:0], 2))
    else $error("index pulse did not follow preset");
  AST_STATUS_RO: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_status |=> param_ack && param_err) else $error("status write not refused");

  COV_FIRST_SETUP: cover property (@(posedge mclk) wr_src && cmd_source == SRC_UNDEFINED);
  COV_PRESET_WRITE: cover property (@(posedge mclk) wr_preset && multi_turn_sensor);
  COV_RESTART_BUSY: cover property (@(posedge mclk) warm_restart && persist_busy);
  COV_MODE_OSC: cover property (@(posedge mclk) wr_mode && param_wdata[15:0] == OPM_OSCILLATOR);

endmodule

// [verilog/drive_params.svh]
`ifndef DRIVE_PARAMS_SVH
`define DRIVE_PARAMS_SVH

// Parameter addresses
`define ADDR_CMD_SOURCE   16'h0502
`define ADDR_ENC_PRESET   16'h052C
`define ADDR_CTRL_WORD    16'h1B02
`define ADDR_STATUS_WORD  16'h1B04
`define ADDR_OPMODE       16'h1B06

// Control word fields
`define CW_SWITCH_ON      0
`define CW_ENABLE_VOLTAGE 1
`define CW_QUICK_STOP     2
`define CW_ENABLE_OP      3
`define CW_MODE_LO        4
`define CW_MODE_HI        6
`define CW_FAULT_RESET    7
`define CW_HALT           8
`define CW_USED_MASK      16'h01FF

// Status word fields
`define SW_VOLTAGE        4
`define SW_WARNING        7
`define SW_HALT           8
`define SW_REMOTE         9
`define SW_TARGET         10
`define SW_MODE_SPEC      12
`define SW_POS_ERR        13
`define SW_REF_OK         15

// Reset values
`define CTRL_RST          16'h0000
`define OPMODE_RST        16'h0000
`define CMD_SRC_RST       2'h0
`define PRESET_RST        32'h00000000

// Encoder geometry
`define POS_PER_REV       32'h00004000
`define MULTI_TURNS       32'h00001000

// Wait before power may be removed after a preset write
`define PERSIST_WAIT_MS   1000
`define CLK_PERIOD_NS     4
`define PERSIST_WAIT_CYC  (`PERSIST_WAIT_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// [verilog/drive_pkg.sv]
package drive_pkg;

  // Operating mode codes, two's complement
  typedef enum logic [15:0] {
    OPM_NONE        = 16'h0000,
    OPM_PROFILE_POS = 16'h0001,
    OPM_PROFILE_VEL = 16'h0003,
    OPM_HOMING      = 16'h0006,
    OPM_JOG         = 16'hFFFF,
    OPM_GEAR        = 16'hFFFE,
    OPM_CURRENT     = 16'hFFFD,
    OPM_SPEED       = 16'hFFFC,
    OPM_OSCILLATOR  = 16'hFFF9
  } op_mode_e;

  // Command source selector codes
  typedef enum logic [1:0] {
    SRC_UNDEFINED = 2'b00,
    SRC_LOCAL_IO  = 2'b01,
    SRC_CANOPEN   = 2'b10,
    SRC_MODBUS    = 2'b11
  } cmd_source_e;

endpackage

// [verilog/persist_timer.sv]
`timescale 1ns/1ns
// Holds busy for WAIT_CYC cycles after start; done pulses as the wait completes
module persist_timer #(
  parameter int unsigned WAIT_CYC = 250000000
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Control
  input  wire logic start,
  input  wire logic abort,
  // Status
  output logic      busy,
  output logic      done
);

  localparam logic [27:0] LAST = 28'(WAIT_CYC - 1);

  logic [27:0] count_r;

  // A fresh start restarts the full wait so the newest value gets its whole second
  always_ff @(posedge mclk) begin
    if (sys_rst || abort) begin
      count_r <= 28'h0000000;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else if (start) begin
      count_r <= 28'h0000000;
      busy    <= 1'b1;
      done    <= 1'b0;
    end else if (busy && count_r == LAST) begin
      busy    <= 1'b0;
      done    <= 1'b1;
    end else begin
      count_r <= busy ? count_r + 28'h0000001 : count_r;
      done    <= 1'b0;
    end
  end

  AST_DONE_ENDS_BUSY: assert property (@(posedge mclk) disable iff (sys_rst)
    done |-> !busy && $past(busy)) else $error("done without a preceding wait");

endmodule

// [tb/fieldbus_master.sv]
`timescale 1ns/1ns
`include "drive_params.svh"
// Fieldbus master: one parameter access at a time, plus power cycling
module fieldbus_master (
  // Clock
  input  wire logic        mclk,
  // Parameter access
  output logic      [15:0] param_addr,
  output logic             param_wr,
  output logic             param_rd,
  output logic      [31:0] param_wdata,
  input  wire logic [31:0] param_rdata,
  input  wire logic        param_ack,
  input  wire logic        param_err,
  // Power control
  output logic             warm_restart,
  input  wire logic        persist_busy
);
  initial begin
    {param_addr, param_wr, param_rd, param_wdata, warm_restart} = '0;
  end

  // Strobe for one edge, answer taken in the following cycle; no inversion input, so none is set first
  task automatic access(input bit wr, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic [1:0] ae);
    logic [31:0] dw;
    dw = d;
    if (wr && a == `ADDR_CTRL_WORD) begin
      dw[31:9] = '0;
    end
    @(posedge mclk);
    param_addr  <= a;
    param_wdata <= dw;
    param_wr    <= wr;
    param_rd    <= !wr;
    @(posedge mclk);
    param_wr    <= 1'b0;
    param_rd    <= 1'b0;
    // Released lines carry the inverse so stale values never look live
    param_addr  <= ~a;
    param_wdata <= ~dw;
    // Answer stands for one cycle after the strobe; take it at the edge that closes that cycle
    @(posedge mclk);
    q  = param_rdata;
    ae = {param_ack, param_err};
  endtask

  // Power is removed after the persist wait or after 1000 cycles of it, whichever is first, unless told to cut it short
  task automatic power_cycle(input bit wait_busy, output bit ok);
    int n;
    n = 0;
    while (wait_busy && persist_busy !== 1'b0 && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    ok = (n < 1000);
    @(posedge mclk);
    warm_restart <= 1'b1;
    @(posedge mclk);
    warm_restart <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ns
`include "drive_params.svh"
module tb;
  import drive_pkg::*;
  localparam int unsigned WAIT = 20;
  localparam logic [15:0] OPM_TAB [8] = '{16'h0001, 16'h0003, 16'h0006, 16'hFFFF,
                                          16'hFFFE, 16'hFFFD, 16'hFFFC, 16'hFFF9};
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        warm_restart;
  logic [15:0] param_addr;
  logic        param_wr;
  logic        param_rd;
  logic [31:0] param_wdata;
  logic [31:0] param_rdata;
  logic        param_ack;
  logic        param_err;
  logic        multi_turn_sensor = 1'b0;
  logic [5:0]  drive_state_bits = 6'h00;
  logic [6:0]  stat_in = 7'h00;  // Voltage, warning, remote, target, mode, pos error, ref ok
  logic [8:0]  ctl_out;          // Control outputs in control word bit order
  op_mode_e    op_mode;
  cmd_source_e cmd_source;
  logic [31:0] enc_preset_active;
  logic [13:0] index_offset;
  logic        persist_busy;
  logic [31:0] q;
  logic [1:0]  ae;
  bit          ok;
  int          err_count = 0;
  int          n_checks = 0;

  // Clock
  always #2 mclk = ~mclk;

  drive_control_param_bank #(.PERSIST_WAIT(WAIT)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .warm_restart(warm_restart), .param_addr(param_addr),
    .param_wr(param_wr), .param_rd(param_rd), .param_wdata(param_wdata), .param_rdata(param_rdata),
    .param_ack(param_ack), .param_err(param_err), .multi_turn_sensor(multi_turn_sensor),
    .drive_state_bits(drive_state_bits), .voltage_enabled(stat_in[0]), .warning(stat_in[1]),
    .remote(stat_in[2]), .target_reached(stat_in[3]), .mode_status(stat_in[4]),
    .position_error(stat_in[5]), .reference_valid(stat_in[6]), .switch_on(ctl_out[0]),
    .enable_voltage(ctl_out[1]), .quick_stop(ctl_out[2]), .enable_operation(ctl_out[3]),
    .mode_ctrl(ctl_out[6:4]), .fault_reset(ctl_out[7]), .halt(ctl_out[8]), .op_mode(op_mode),
    .cmd_source(cmd_source), .enc_preset_active(enc_preset_active), .index_offset(index_offset),
    .persist_busy(persist_busy));

  fieldbus_master fm (
    .mclk(mclk), .param_addr(param_addr), .param_wr(param_wr), .param_rd(param_rd),
    .param_wdata(param_wdata), .param_rdata(param_rdata), .param_ack(param_ack),
    .param_err(param_err), .warm_restart(warm_restart), .persist_busy(persist_busy));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] exp_ae);
    fm.access(1'b1, a, d, q, ae);
    chk("write answer", {30'h0, exp_ae}, {30'h0, ae});
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] exp_ae);
    fm.access(1'b0, a, 32'h0, q, ae);
    chk("read answer", {30'h0, exp_ae}, {30'h0, ae});
    chk("read data", exp, q);
  endtask

  // Status word as laid out by the bit map, halt taken from the control word
  function automatic logic [31:0] exp_status(input logic [5:0] st, input logic [6:0] s, input logic h);
    return {16'h0, s[6], 1'b0, s[5], s[4], 1'b0, s[3], s[2], h, s[1], st[5:4], s[0], st[3:0]};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("command source", 32'h0, {30'h0, cmd_source});
    rd(`ADDR_CMD_SOURCE, 32'h0, 2'b10);
    rd(16'h1B08, 32'h0, 2'b11);
    $display("test reset done");
    foreach (OPM_TAB[i]) begin
      wr(`ADDR_CTRL_WORD, {16'h0, OPM_TAB[i] ^ 16'h01A5}, 2'b10);
      chk("control outputs", {23'h0, OPM_TAB[i][8:0] ^ 9'h1A5}, {23'h0, ctl_out});
      rd(`ADDR_CTRL_WORD, {23'h0, OPM_TAB[i][8:0] ^ 9'h1A5}, 2'b10);
      wr(`ADDR_OPMODE, {16'h0, OPM_TAB[i]}, 2'b10);
      chk("operating mode", {16'h0, OPM_TAB[i]}, {16'h0, op_mode});
    end
    wr(`ADDR_OPMODE, 32'h0002, 2'b11);
    wr(`ADDR_OPMODE, 32'hFFFA, 2'b11);
    rd(`ADDR_OPMODE, 32'hFFF9, 2'b10);
    $display("test control and mode done");
    for (int i = 0; i < 2; i++) begin
      wr(`ADDR_CTRL_WORD, {23'h0, i[0], 8'h00}, 2'b10);
      drive_state_bits <= i[0] ? 6'h15 : 6'h2A;
      stat_in <= i[0] ? 7'h12 : 7'h6D;
      repeat (2) @(posedge mclk);
      rd(`ADDR_STATUS_WORD, exp_status(drive_state_bits, stat_in, i[0]), 2'b10);
      wr(`ADDR_STATUS_WORD, 32'h0000FFFF, 2'b11);
      rd(`ADDR_STATUS_WORD, exp_status(drive_state_bits, stat_in, i[0]), 2'b10);
    end
    $display("test status done");
    wr(`ADDR_CMD_SOURCE, 32'h2, 2'b10);
    chk("command source", 32'h2, {30'h0, cmd_source});
    wr(`ADDR_CMD_SOURCE, 32'h3, 2'b10);
    wr(`ADDR_CMD_SOURCE, 32'h4, 2'b11);
    chk("command source", 32'h2, {30'h0, cmd_source});
    rd(`ADDR_CMD_SOURCE, 32'h3, 2'b10);
    fm.power_cycle(1'b1, ok);
    chk("command source", 32'h3, {30'h0, cmd_source});
    wr(`ADDR_CMD_SOURCE, 32'h1, 2'b10);
    fm.power_cycle(1'b1, ok);
    chk("command source", 32'h1, {30'h0, cmd_source});
    $display("test command source done");
    wr(`ADDR_ENC_PRESET, `POS_PER_REV - 1, 2'b10);
    chk("persist busy", 32'h1, {31'h0, persist_busy});
    wr(`ADDR_ENC_PRESET, `POS_PER_REV, 2'b11);
    chk("active preset", 32'h0, enc_preset_active);
    fm.power_cycle(1'b1, ok);
    chk("persist wait ended", 32'h1, {31'h0, ok});
    chk("active preset", `POS_PER_REV - 1, enc_preset_active);
    chk("index offset", 32'h3FFF, {18'h0, index_offset});
    @(posedge mclk);
    multi_turn_sensor <= 1'b1;
    wr(`ADDR_ENC_PRESET, `POS_PER_REV * `MULTI_TURNS - 1, 2'b10);
    wr(`ADDR_ENC_PRESET, `POS_PER_REV * `MULTI_TURNS, 2'b11);
    fm.power_cycle(1'b0, ok);
    chk("active preset", `POS_PER_REV - 1, enc_preset_active);
    rd(`ADDR_ENC_PRESET, `POS_PER_REV - 1, 2'b10);
    wr(`ADDR_ENC_PRESET, 32'h02001234, 2'b10);
    fm.power_cycle(1'b1, ok);
    chk("active preset", 32'h02001234, enc_preset_active);
    chk("index offset", 32'h1234, {18'h0, index_offset});
    $display("test preset done");
    summarize();
  end
endmodule
